// [design/codec_audio_format_agc_map.vh]
// register indices, field positions, reset values and timing counts of the audio format / agc registers
`ifndef CODEC_AUDIO_FORMAT_AGC_MAP_VH
`define CODEC_AUDIO_FORMAT_AGC_MAP_VH

// register indices; byte address is four times the index
`define IDX_AUDIO_CONTROL_ONE      4'h0
`define IDX_HEADSET_INPUT_GAIN_AGC 4'h1
`define IDX_INPUT_SOURCE_SELECT    4'h3
`define IDX_RESERVED_FILL          4'he
`define IDX_STATUS                 4'h4

// audio_control_one fields
`define HPF_MSB   15
`define HPF_LSB   14
`define WID_MSB   11
`define WID_LSB   10
`define FMT_MSB   9
`define FMT_LSB   8
`define PDIV_MSB  5
`define PDIV_LSB  3
`define RDIV_MSB  2
`define RDIV_LSB  0

// headset_input_gain_agc fields
`define MUTE_BIT  15
`define PGA_MSB   14
`define PGA_LSB   8
`define TG_MSB    7
`define TG_LSB    5
`define TC_MSB    4
`define TC_LSB    1
`define AGCEN_BIT 0

// input source select field
`define SRC_MSB 7
`define SRC_LSB 5

// reset values
`define RST_HPF      2'h0
`define RST_WID      2'h0
`define RST_FMT      2'h0
`define RST_RATE     3'h0
`define RST_MUTE     1'h1
`define RST_PGA      7'h7f
`define RST_TG       3'h0
`define RST_TC       4'h0
`define RST_AGCEN    1'h0
`define RST_SRC      3'h0
`define RST_FILL     8'hff

// right justified frame code
`define FMT_RIGHT     2'h2

// agc time base: one millisecond in system clocks
`define MS_CYCLES     250000

`endif

// [design/rate_tick_divider.v]
// fractional divider that turns the reference sample tick into a converter sample tick
`timescale 1ns/10ps
`include "codec_audio_format_agc_map.vh"

module rate_tick_divider (
    input  wire       clk_sys_i,    // system clock
    input  wire       reset_i,      // async reset, active high
    input  wire       ref_tick_i,   // one pulse per reference sample
    input  wire [2:0] rate_code_i,  // divider code
    output reg        rate_tick_o   // one pulse per converter sample
);

    reg  [3:0] half_div;            // divisor in half units
    reg  [4:0] acc_reg;
    reg  [4:0] acc_next;
    reg        tick_next;
    wire [4:0] acc_sum;

    // divisor table; 101 and 110 both divide by five
    always @* begin
        case (rate_code_i)
            3'h0:    half_div = 4'h2;
            3'h1:    half_div = 4'h3;
            3'h2:    half_div = 4'h4;
            3'h3:    half_div = 4'h6;
            3'h4:    half_div = 4'h8;
            3'h5:    half_div = 4'ha;
            3'h6:    half_div = 4'ha;
            default: half_div = 4'hc;
        endcase
    end

    // each reference tick adds two halves; divide by 1.5 gives two ticks per three
    assign acc_sum = acc_reg + 5'h2;

    always @* begin
        acc_next  = acc_reg;
        tick_next = 1'b0;
        if (ref_tick_i) begin
            if (acc_sum >= {1'b0, half_div}) begin
                acc_next  = acc_sum - {1'b0, half_div};
                tick_next = 1'b1;
            end else begin
                acc_next = acc_sum;
            end
        end
    end

    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            acc_reg     <= 5'h0;
            rate_tick_o <= 1'b0;
        end else begin
            acc_reg     <= acc_next;
            rate_tick_o <= tick_next;
        end
    end

endmodule // rate_tick_divider

// [design/codec_audio_format_agc_regs.v]
// ahb-lite register bank for audio format, sample rates, headset gain and agc settings
`timescale 1ns/10ps
`include "codec_audio_format_agc_map.vh"

module codec_audio_format_agc_regs #(
    parameter MS_CYCLES = `MS_CYCLES                // clocks per millisecond
) (
    input  wire        clk_sys_i,                   // system clock, 250 MHz
    input  wire        reset_i,                     // async reset, active high
    input  wire        hsel_i,                      // ahb slave select
    input  wire [31:0] haddr_i,                     // ahb address
    input  wire [1:0]  htrans_i,                    // ahb transfer type
    input  wire        hwrite_i,                    // ahb write
    input  wire [2:0]  hsize_i,                     // ahb size, word only
    input  wire [31:0] hwdata_i,                    // ahb write data
    input  wire        hready_i,                    // ahb bus ready
    output wire        hreadyout_o,                 // ahb slave ready
    output wire        hresp_o,                     // ahb response, always okay
    output reg  [31:0] hrdata_o,                    // ahb read data
    input  wire        ref_tick_i,                  // reference sample tick, same clock
    input  wire [7:0]  agc_gain_i,                  // signed gain applied by agc loop
    output wire [1:0]  adc_highpass_select_o,       // highpass corner code
    output wire        highpass_enable_o,           // highpass filter active
    output wire [1:0]  sample_word_width_o,         // word width code
    output reg  [5:0]  sample_bits_o,               // serial sample width in bits
    output wire [1:0]  serial_frame_format_o,       // frame format code
    output wire        format_ratio_invalid_o,      // right justified with bad ratio
    output wire        playback_tick_o,             // dac sample tick
    output wire        record_tick_o,               // adc sample tick
    output wire        headset_path_active_o,       // headset/aux input feeds the adc
    output wire [2:0]  input_source_select_o,       // adc input source code
    output wire        pga_mute_o,                  // mute applied to headset pga by registers
    output wire [6:0]  pga_gain_o,                  // gain applied to headset pga by registers
    output wire        agc_active_o,                // agc loop owns the headset pga
    output reg  [7:0]  auto_gain_target_o,          // target level, signed half-db units
    output wire [3:0]  auto_gain_time_constants_o,  // time constant code
    output reg         attack_tick_o,               // one pulse per attack period
    output reg         decay_tick_o,                // one pulse per decay period
    output wire [7:0]  reserved_fill_byte_o         // stored fill byte
);

    // register storage
    reg [1:0]  hpf_reg;
    reg [1:0]  wid_reg;
    reg [1:0]  fmt_reg;
    reg [2:0]  pdiv_reg;
    reg [2:0]  rdiv_reg;
    reg        mute_reg;
    reg [6:0]  pga_reg;
    reg [2:0]  tg_reg;
    reg [3:0]  tc_reg;
    reg        agcen_reg;
    reg [2:0]  src_reg;
    reg [7:0]  fill_reg;

    // bus pipeline state
    reg        wr_pend_reg;
    reg        rd_pend_reg;
    reg [3:0]  idx_reg;
    reg        mapped_reg;
    reg [15:0] rd_word;

    wire       take;
    wire       addr_mapped;

    // taken when selected, nonseq/seq and the bus is ready
    assign take        = hsel_i & htrans_i[1] & hready_i;
    assign addr_mapped = (haddr_i[31:6] == 26'h0) & (haddr_i[1:0] == 2'h0);
    // reads take one wait state so a preceding write is always visible
    assign hreadyout_o = ~rd_pend_reg;
    assign hresp_o     = 1'b0;

    // address phase capture
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            idx_reg     <= 4'h0;
            mapped_reg  <= 1'b0;
        end else begin
            if (rd_pend_reg) begin
                rd_pend_reg <= 1'b0;
            end else begin
                wr_pend_reg <= take & hwrite_i;
                rd_pend_reg <= take & ~hwrite_i;
                idx_reg     <= haddr_i[5:2];
                mapped_reg  <= addr_mapped;
            end
        end
    end

    // data phase writes; reserved bits are not stored, except the fill byte, which is kept as written
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            hpf_reg   <= `RST_HPF;
            wid_reg   <= `RST_WID;
            fmt_reg   <= `RST_FMT;
            pdiv_reg  <= `RST_RATE;
            rdiv_reg  <= `RST_RATE;
            mute_reg  <= `RST_MUTE;
            pga_reg   <= `RST_PGA;
            tg_reg    <= `RST_TG;
            tc_reg    <= `RST_TC;
            agcen_reg <= `RST_AGCEN;
            src_reg   <= `RST_SRC;
            fill_reg  <= `RST_FILL;
        end else if (wr_pend_reg && mapped_reg) begin
            case (idx_reg)
                `IDX_AUDIO_CONTROL_ONE: begin
                    hpf_reg   <= hwdata_i[`HPF_MSB:`HPF_LSB];
                    wid_reg   <= hwdata_i[`WID_MSB:`WID_LSB];
                    fmt_reg   <= hwdata_i[`FMT_MSB:`FMT_LSB];
                    pdiv_reg  <= hwdata_i[`PDIV_MSB:`PDIV_LSB];
                    rdiv_reg  <= hwdata_i[`RDIV_MSB:`RDIV_LSB];
                end
                `IDX_HEADSET_INPUT_GAIN_AGC: begin
                    // written gain is kept even while the loop owns the pga
                    mute_reg  <= hwdata_i[`MUTE_BIT];
                    pga_reg   <= hwdata_i[`PGA_MSB:`PGA_LSB];
                    tg_reg    <= hwdata_i[`TG_MSB:`TG_LSB];
                    tc_reg    <= hwdata_i[`TC_MSB:`TC_LSB];
                    agcen_reg <= hwdata_i[`AGCEN_BIT];
                end
                `IDX_INPUT_SOURCE_SELECT: begin
                    src_reg <= hwdata_i[`SRC_MSB:`SRC_LSB];
                end
                `IDX_RESERVED_FILL: begin
                    // software is expected to write ones only; the value is kept as written
                    fill_reg <= hwdata_i[15:8];
                end
                default: begin
                    fill_reg <= fill_reg;
                end
            endcase
        end
    end

    // headset path: every source except the handset mic, alone or in a pair
    assign headset_path_active_o = (src_reg != 3'h1) && (src_reg[2:1] != 2'h3);
    assign agc_active_o          = agcen_reg & headset_path_active_o;

    // read mux; reserved bits read zero, except the fill byte, which reads back as stored
    always @* begin
        rd_word = 16'h0;
        case (idx_reg)
            `IDX_AUDIO_CONTROL_ONE: begin
                rd_word = {hpf_reg, 2'h0, wid_reg, fmt_reg, 2'h0, pdiv_reg, rdiv_reg};
            end
            `IDX_HEADSET_INPUT_GAIN_AGC: begin
                if (agc_active_o) begin
                    rd_word = {agc_gain_i, tg_reg, tc_reg, agcen_reg};
                end else begin
                    rd_word = {mute_reg, pga_reg, tg_reg, tc_reg, agcen_reg};
                end
            end
            `IDX_INPUT_SOURCE_SELECT: begin
                rd_word = {8'h0, src_reg, 5'h0};
            end
            `IDX_STATUS: begin
                rd_word = {15'h0, format_ratio_invalid_o};
            end
            `IDX_RESERVED_FILL: begin
                rd_word = {fill_reg, 8'h0};
            end
            default: begin
                rd_word = 16'h0;
            end
        endcase
    end

    // read data registered in the wait cycle; unmapped reads return zero
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            hrdata_o <= 32'h0;
        end else if (rd_pend_reg) begin
            hrdata_o <= mapped_reg ? {16'h0, rd_word} : 32'h0;
        end
    end

    // format and filter outputs
    assign adc_highpass_select_o = hpf_reg;
    assign highpass_enable_o     = (hpf_reg != 2'h0);
    assign sample_word_width_o   = wid_reg;
    assign serial_frame_format_o = fmt_reg;

    // serial sample width decode
    always @* begin
        case (wid_reg)
            2'h0:    sample_bits_o = 6'h10;
            2'h1:    sample_bits_o = 6'h14;
            2'h2:    sample_bits_o = 6'h18;
            default: sample_bits_o = 6'h20;
        endcase
    end

    // right-justified check: divisors in half units must divide one another
    function [3:0] half_div;
        input [2:0] code;
        begin
            case (code)
                3'h0:    half_div = 4'h2;
                3'h1:    half_div = 4'h3;
                3'h2:    half_div = 4'h4;
                3'h3:    half_div = 4'h6;
                3'h4:    half_div = 4'h8;
                3'h5:    half_div = 4'ha;
                3'h6:    half_div = 4'ha;
                default: half_div = 4'hc;
            endcase
        end
    endfunction

    wire [3:0] dac_half = half_div(pdiv_reg);
    wire [3:0] adc_half = half_div(rdiv_reg);
    wire       ratio_int = ((dac_half % adc_half) == 4'h0) || ((adc_half % dac_half) == 4'h0);
    // flagged only; the serial port still runs whatever software chose
    assign format_ratio_invalid_o = (fmt_reg == `FMT_RIGHT) && !ratio_int;

    // converter sample ticks
    rate_tick_divider u_playback_rate (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .ref_tick_i  (ref_tick_i),
        .rate_code_i (pdiv_reg),
        .rate_tick_o (playback_tick_o)
    );

    rate_tick_divider u_record_rate (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .ref_tick_i  (ref_tick_i),
        .rate_code_i (rdiv_reg),
        .rate_tick_o (record_tick_o)
    );

    // source code, manual pga settings, time constant code and fill byte
    assign input_source_select_o      = src_reg;
    assign pga_mute_o                 = mute_reg;
    assign pga_gain_o                 = pga_reg;
    assign auto_gain_time_constants_o = tc_reg;
    assign reserved_fill_byte_o       = fill_reg;

    // target level in signed half-db units
    always @* begin
        case (tg_reg)
            3'h0:    auto_gain_target_o = 8'hf5;
            3'h1:    auto_gain_target_o = 8'hf0;
            3'h2:    auto_gain_target_o = 8'hec;
            3'h3:    auto_gain_target_o = 8'he8;
            3'h4:    auto_gain_target_o = 8'he4;
            3'h5:    auto_gain_target_o = 8'hde;
            3'h6:    auto_gain_target_o = 8'hd8;
            default: auto_gain_target_o = 8'hd0;
        endcase
    end

    // attack and decay periods in ms, from the system clock so sample rate does not change them
    reg [4:0]  attack_ms;
    reg [8:0]  decay_ms;
    reg [17:0] ms_cnt_reg;
    reg        ms_tick_reg;
    reg [4:0]  att_cnt_reg;
    reg [8:0]  dec_cnt_reg;

    always @* begin
        case (tc_reg[1:0])
            2'h0:    attack_ms = 5'h08;
            2'h1:    attack_ms = 5'h0b;
            2'h2:    attack_ms = 5'h10;
            default: attack_ms = 5'h14;
        endcase
        case (tc_reg[3:2])
            2'h0:    decay_ms = 9'h064;
            2'h1:    decay_ms = 9'h0c8;
            2'h2:    decay_ms = 9'h190;
            default: decay_ms = 9'h1f4;
        endcase
    end

    // millisecond base and period counters; idle while the loop is off
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ms_cnt_reg    <= 18'h0;
            ms_tick_reg   <= 1'b0;
            att_cnt_reg   <= 5'h0;
            dec_cnt_reg   <= 9'h0;
            attack_tick_o <= 1'b0;
            decay_tick_o  <= 1'b0;
        end else begin
            attack_tick_o <= 1'b0;
            decay_tick_o  <= 1'b0;
            ms_tick_reg   <= 1'b0;
            if (!agc_active_o) begin
                ms_cnt_reg  <= 18'h0;
                att_cnt_reg <= 5'h0;
                dec_cnt_reg <= 9'h0;
            end else begin
                if (ms_cnt_reg == MS_CYCLES[17:0] - 18'h1) begin
                    ms_cnt_reg  <= 18'h0;
                    ms_tick_reg <= 1'b1;
                end else begin
                    ms_cnt_reg <= ms_cnt_reg + 18'h1;
                end
                if (ms_tick_reg) begin
                    // a shortened code takes effect at once; a count already past it wraps on the next millisecond
                    if (att_cnt_reg >= attack_ms - 5'h1) begin
                        att_cnt_reg   <= 5'h0;
                        attack_tick_o <= 1'b1;
                    end else begin
                        att_cnt_reg <= att_cnt_reg + 5'h1;
                    end
                    if (dec_cnt_reg >= decay_ms - 9'h1) begin
                        dec_cnt_reg  <= 9'h0;
                        decay_tick_o <= 1'b1;
                    end else begin
                        dec_cnt_reg <= dec_cnt_reg + 9'h1;
                    end
                end
            end
        end
    end

endmodule // codec_audio_format_agc_regs

// [testbench/codec_audio_format_agc_regs_properties.sv]
// concurrent checks on the ports of the audio format / agc register bank
`timescale 1ns/10ps
module codec_audio_format_agc_regs_properties #(
    parameter MS_CYCLES = 10                        // clocks per millisecond
) (
    input wire logic        clk_sys_i,                  // system clock
    input wire logic        reset_i,                    // async reset, active high
    input wire logic        hsel_i,                     // slave select
    input wire logic [1:0]  htrans_i,                   // transfer type
    input wire logic        hwrite_i,                   // write strobe
    input wire logic        hready_i,                   // bus ready
    input wire logic        hreadyout_o,                // slave ready
    input wire logic [31:0] hrdata_o,                   // read data
    input wire logic        ref_tick_i,                 // reference tick
    input wire logic [1:0]  adc_highpass_select_o,      // highpass code
    input wire logic        highpass_enable_o,          // highpass on
    input wire logic [1:0]  sample_word_width_o,        // width code
    input wire logic [5:0]  sample_bits_o,              // width in bits
    input wire logic [1:0]  serial_frame_format_o,      // frame format
    input wire logic        format_ratio_invalid_o,     // bad ratio flag
    input wire logic        playback_tick_o,            // dac tick
    input wire logic        record_tick_o,              // adc tick
    input wire logic        headset_path_active_o,      // headset path
    input wire logic [2:0]  input_source_select_o,      // source code
    input wire logic        agc_active_o,               // agc owns pga
    input wire logic [3:0]  auto_gain_time_constants_o, // time constant code
    input wire logic        attack_tick_o               // attack period tick
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    int   gap_reg;
    logic have_reg;

    function automatic int attack_ms(input logic [1:0] c);
        return (c == 2'h0) ? 8 : (c == 2'h1) ? 11 : (c == 2'h2) ? 16 : 20;
    endfunction

    // cycles since the last attack tick; code change or agc drop voids it
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            gap_reg  <= 0;
            have_reg <= 1'b0;
        end else begin
            gap_reg  <= attack_tick_o ? 1 : gap_reg + 1;
            have_reg <= (!agc_active_o || $changed(auto_gain_time_constants_o)) ? 1'b0 :
                        (attack_tick_o ? 1'b1 : have_reg);
        end
    end

    a_hpf_enable_decode: assert property (highpass_enable_o == (adc_highpass_select_o != 2'h0))
        else $error("highpass enable disagrees with its code");
    a_width_bits_decode: assert property (sample_bits_o == ((sample_word_width_o == 2'h0) ? 6'h10 :
        (sample_word_width_o == 2'h1) ? 6'h14 : (sample_word_width_o == 2'h2) ? 6'h18 : 6'h20))
        else $error("sample width decode wrong");
    a_ratio_needs_right: assert property (format_ratio_invalid_o |-> serial_frame_format_o == 2'h2)
        else $error("ratio flag outside right justified");
    a_headset_path_decode: assert property (headset_path_active_o ==
        !(input_source_select_o inside {3'h1, 3'h6, 3'h7})) else $error("headset path decode wrong");
    a_agc_needs_path: assert property (agc_active_o |-> headset_path_active_o)
        else $error("agc active without headset path");
    a_play_tick_cause: assert property (playback_tick_o |-> $past(ref_tick_i))
        else $error("playback tick without reference tick");
    a_rec_tick_cause: assert property (record_tick_o |-> $past(ref_tick_i))
        else $error("record tick without reference tick");
    a_attack_needs_agc: assert property (attack_tick_o |-> $past(agc_active_o))
        else $error("attack tick while agc idle");
    a_attack_period_exact: assert property (attack_tick_o && have_reg && $stable(auto_gain_time_constants_o)
        |-> gap_reg == attack_ms(auto_gain_time_constants_o[1:0]) * MS_CYCLES) else $error("attack period wrong");
    a_upper_half_zero: assert property (hreadyout_o |-> hrdata_o[31:16] == 16'h0)
        else $error("read data upper half not zero");
    a_read_wait_one: assert property (hsel_i && htrans_i[1] && hready_i && !hwrite_i
        |=> !hreadyout_o ##1 hreadyout_o) else $error("read wait state wrong");

    c_read: cover property (!hreadyout_o ##1 hreadyout_o);
    c_attack: cover property (attack_tick_o && have_reg);
    c_ratio: cover property (format_ratio_invalid_o);
    c_play: cover property (playback_tick_o && record_tick_o);
endmodule // codec_audio_format_agc_regs_properties

bind codec_audio_format_agc_regs codec_audio_format_agc_regs_properties #(.MS_CYCLES(MS_CYCLES)) u_props (.*);

// [testbench/test_codec_audio_format_agc_regs.sv]
// self-checking bench for the audio format / agc register bank
`timescale 1ns/10ps
module test_codec_audio_format_agc_regs;
    localparam MSC = 10;                    // short millisecond keeps agc periods brief
    logic        clk_sys_i  = 1'b0;
    logic        reset_i    = 1'b1;
    logic        hsel_i     = 1'b0;
    logic [31:0] haddr_i    = 32'h0;
    logic [1:0]  htrans_i   = 2'h0;
    logic        hwrite_i   = 1'b0;
    logic [31:0] hwdata_i   = 32'h0;
    logic        ref_tick_i = 1'b0;
    logic [7:0]  agc_gain_i = 8'he8;
    wire         hreadyout_o, hresp_o, highpass_enable_o, format_ratio_invalid_o, playback_tick_o;
    wire         record_tick_o, headset_path_active_o, pga_mute_o, agc_active_o, attack_tick_o, decay_tick_o;
    wire [31:0]  hrdata_o;
    wire [1:0]   adc_highpass_select_o, serial_frame_format_o;
    wire [5:0]   sample_bits_o;
    wire [6:0]   pga_gain_o;
    wire [7:0]   auto_gain_target_o, reserved_fill_byte_o;
    int          num_errors  = 0;
    int          checks_done = 0;
    int          halves[8]   = '{2, 3, 4, 6, 8, 10, 10, 12};
    int          am[4]       = '{8, 11, 16, 20};
    int          dm[4]       = '{100, 200, 400, 500};
    logic [5:0]  bits[4]     = '{6'h10, 6'h14, 6'h18, 6'h20};
    logic [7:0]  tgt[8]      = '{8'hf5, 8'hf0, 8'hec, 8'he8, 8'he4, 8'hde, 8'hd8, 8'hd0};

    codec_audio_format_agc_regs #(.MS_CYCLES(MSC)) u_codec_audio_format_agc_regs (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .ref_tick_i(ref_tick_i),
        .agc_gain_i(agc_gain_i), .adc_highpass_select_o(adc_highpass_select_o),
        .highpass_enable_o(highpass_enable_o), .sample_word_width_o(), .sample_bits_o(sample_bits_o),
        .serial_frame_format_o(serial_frame_format_o), .format_ratio_invalid_o(format_ratio_invalid_o),
        .playback_tick_o(playback_tick_o), .record_tick_o(record_tick_o),
        .headset_path_active_o(headset_path_active_o), .input_source_select_o(), .pga_mute_o(pga_mute_o),
        .pga_gain_o(pga_gain_o), .agc_active_o(agc_active_o), .auto_gain_target_o(auto_gain_target_o),
        .auto_gain_time_constants_o(), .attack_tick_o(attack_tick_o), .decay_tick_o(decay_tick_o),
        .reserved_fill_byte_o(reserved_fill_byte_o));

    // free-running system clock
    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    task close_out;
        $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task step;
        @(posedge clk_sys_i);
    endtask

    // bounded wait for ready at a rising edge
    task wait_rdy;
        int n;
        n = 0;
        do begin
            step;
            n++;
            if (n > 50) begin
                num_errors++;
                close_out;
            end
        end while (hreadyout_o !== 1'b1);
    endtask

    task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel_i <= 1'b1;
        haddr_i <= a;
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        wait_rdy;
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        wait_rdy;
        q = hrdata_o;
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
        step;
    endtask

    task rchk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    task do_reset;
        reset_i <= 1'b1;
        repeat (12) step;
        reset_i <= 1'b0;
    endtask

    // every field at its reset value through the bus; mute, gain, fill byte and sample width at the ports
    task t_reset;
        rchk(32'h00, 32'h0);
        rchk(32'h04, 32'hff00);
        rchk(32'h0c, 32'h0);
        rchk(32'h38, 32'hff00);
        rchk(32'h10, 32'h0);
        chk(pga_mute_o, 1'b1);
        chk(pga_gain_o, 7'h7f);
        chk(reserved_fill_byte_o, 8'hff);
        chk(sample_bits_o, 6'h10);
    endtask

    // reserved bits, unmapped places, then every format code
    task t_ctrl;
        wr(32'h00, 32'hffff);
        rchk(32'h00, 32'hcf3f);
        wr(32'h20, 32'h1234);
        rchk(32'h20, 32'h0);
        rchk(32'h02, 32'h0);
        chk(hresp_o, 1'b0);
        wr(32'h38, 32'hff00);
        rchk(32'h38, 32'hff00);
        for (int i = 0; i < 4; i++) begin
            wr(32'h00, (i << 14) | (i << 10) | (i << 8));
            chk(adc_highpass_select_o, i[1:0]);
            chk(highpass_enable_o, i != 0);
            chk(sample_bits_o, bits[i]);
            chk(serial_frame_format_o, i[1:0]);
        end
    endtask

    // both dividers from a fresh accumulator, right justified framing
    task t_rates;
        int np, nr;
        logic inv;
        for (int c = 0; c < 8; c++) begin
            do_reset;
            wr(32'h00, 32'h200 | (c << 3) | (7 - c));
            np = 0;
            nr = 0;
            for (int n = 0; n < 240; n++) begin
                ref_tick_i <= (n % 4 == 0);
                step;
                np += (playback_tick_o === 1'b1);
                nr += (record_tick_o === 1'b1);
            end
            chk(np, 120 / halves[c]);
            chk(nr, 120 / halves[7 - c]);
            inv = (halves[c] % halves[7 - c] != 0) && (halves[7 - c] % halves[c] != 0);
            chk(format_ratio_invalid_o, inv);
            rchk(32'h10, inv);
        end
    endtask

    // written gain, target table, then the agc loop over every source
    task t_gain;
        logic hp;
        wr(32'h04, 32'h1200);
        chk(pga_mute_o, 1'b0);
        chk(pga_gain_o, 7'h12);
        for (int t = 0; t < 8; t++) begin
            wr(32'h04, 32'h1200 | (t << 5));
            chk(auto_gain_target_o, tgt[t]);
        end
        wr(32'h04, 32'h1201);
        for (int s = 0; s < 8; s++) begin
            if (s == 4) agc_gain_i <= 8'h77;
            wr(32'h0c, s << 5);
            hp = !(s == 1 || s == 6 || s == 7);
            chk(headset_path_active_o, hp);
            chk(agc_active_o, hp);
            rchk(32'h04, hp ? {16'h0, agc_gain_i, 8'h01} : 32'h1201);
        end
        wr(32'h0c, 32'h0);
        wr(32'h04, 32'h1200);
        chk(agc_active_o, 1'b0);
        chk(pga_gain_o, 7'h12);
    endtask

    // span between two successive attack or decay ticks
    task gap(input logic dec, input int exp);
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                step;
                n++;
                if (n > 12000) begin
                    num_errors++;
                    close_out;
                end
            end while ((dec ? decay_tick_o : attack_tick_o) !== 1'b1);
        end
        chk(n, exp);
    endtask

    task t_times;
        for (int k = 0; k < 4; k++) begin
            wr(32'h04, 32'h1201 | ((k * 5) << 1));
            gap(1'b0, am[k] * MSC);
            gap(1'b1, dm[k] * MSC);
        end
    endtask

    initial begin
        do_reset;
        t_reset;
        t_ctrl;
        t_gain;
        t_times;
        t_rates;
        close_out;
    end
endmodule // test_codec_audio_format_agc_regs
